// ===== see_map.vh
// Constants for the serial memory target: bus framing, page layout,
// erased value and write cycle timing.
// Assumes the includer runs on a 4 ns core clock.
`ifndef SEE_MAP_VH
`define SEE_MAP_VH

// Core clock period and internal write cycle time, both in ns
`define SEE_CLK_NS        4
`define SEE_WRCYC_NS      5000000

// Byte framing: data bits counted 1..8, acknowledge clock is the 9th
`define SEE_BITS_LAST     4'h8
`define SEE_BIT_ACK       4'h9
`define SEE_BIT_NONE      4'h0

// Target address byte layout
`define SEE_TYPE_HI       7
`define SEE_TYPE_LO       4
`define SEE_SEL_HI        3
`define SEE_SEL_LO        1
`define SEE_RW_BIT        0

// Page organisation
`define SEE_PAGE_BYTES    16
`define SEE_PAGE_W        4
`define SEE_LOW_ADDR_INC  4'h1

// Erased content of every byte
`define SEE_ERASED        8'hff

`endif

// ===== see_fifo.v
// Small valid/ready buffer for received write bytes.
// Assumes both sides run on the same clock; depth is 2 to the AW.
`timescale 1ns/10ps
module see_fifo #(
	parameter W  = 12,
	parameter AW = 1
) (
	input  wire         clk_i,
	input  wire         rst_b_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	localparam DEPTH = 1 << AW;
	localparam [AW:0] FULL_CNT = DEPTH;

	reg [W-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0]   count;

	wire do_push = in_valid_i & in_ready_o;
	wire do_pop  = out_valid_o & out_ready_i;

	// Full and empty come straight from the occupancy count
	assign in_ready_o  = (count != FULL_CNT);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = store[rd_ptr];

	// Pointers wrap naturally because depth is a power of two
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				store[wr_ptr] <= in_data_i;
				wr_ptr        <= wr_ptr + 1'b1;
			end
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (do_push & ~do_pop)
				count <= count + 1'b1;
			else if (do_pop & ~do_push)
				count <= count - 1'b1;
		end
	end
endmodule

// ===== see_target.v
// Functional notes
// - Reset returns to standby, idle bus state
// - Sample on SCL rise, drive after fall
// - Zero pulls SDA low, one releases
// - SDA edges during SCL high frame commands
// - Ignore traffic until START, then address
// - Upper nibble must equal type code
// - Strap bits compared unless used as address
// - Acknowledge address and every written byte; code gives no ack to a data byte when protect is set or the queue is full
// - Read: eight bits, release, continue on ack
// - Byte write: address, data, STOP commits
// - Busy writing: SDA released, no response
// - Page write increments low four bits
// - Over sixteen bytes wraps, overwrites buffer
// - STOP commits whole page in one cycle
// - No ack while busy, ack after
// - Write protect high blocks all writes
// - Protect sampled before first data byte
// - Array starts erased, all bytes FF
// - Read address sends byte at pointer
// - Sequential read wraps at memory end
//
// Two-wire target of a page-organised nonvolatile memory.
// Assumes SCL, SDA, protect and strap pins are asynchronous to ref_clk_i
// and that SCL is far slower than the core clock.
`timescale 1ns/10ps
`include "see_map.vh"
module see_target #(
	parameter ADDR_BITS = 11,
	parameter [3:0] DEV_TYPE = 4'h5,
	parameter [23:0] WR_CYCLES = `SEE_WRCYC_NS / `SEE_CLK_NS
) (
	input  wire ref_clk_i,
	input  wire rst_b_i,
	input  wire scl_i,
	input  wire sda_i,
	output reg  sda_o,
	output reg  sda_oe_b_o,
	input  wire wp_i,
	input  wire strap_select_bit0_i,
	input  wire strap_select_bit1_i,
	input  wire strap_select_bit2_i,
	output reg  write_busy_o
);
	// DEV_TYPE default is an arbitrary value, set it per product

	localparam MEM_BYTES = 1 << ADDR_BITS;
	localparam NSEL      = ADDR_BITS - 8;
	localparam PB_W      = ADDR_BITS - `SEE_PAGE_W;
	localparam [2:0] CMP_MASK = 3'h7 << NSEL;

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_DEV   = 3'h1;
	localparam [2:0] ST_WADDR = 3'h2;
	localparam [2:0] ST_DATA  = 3'h3;
	localparam [2:0] ST_TX    = 3'h4;

	// Pin synchronisers; stage 3 of SCL/SDA only feeds edge detection
	reg [2:0] scl_s;
	reg [2:0] sda_s;
	reg [1:0] wp_s;
	reg [2:0] strap_m;
	reg [2:0] strap_s;

	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_s   <= 3'h7;
			sda_s   <= 3'h7;
			wp_s    <= 2'h0;
			strap_m <= 3'h0;
			strap_s <= 3'h0;
		end else begin
			scl_s   <= {scl_s[1:0], scl_i};
			sda_s   <= {sda_s[1:0], sda_i};
			wp_s    <= {wp_s[0], wp_i};
			strap_m <= {strap_select_bit2_i, strap_select_bit1_i,
				strap_select_bit0_i};
			strap_s <= strap_m;
		end
	end

	wire scl_now  = scl_s[1];
	wire scl_prev = scl_s[2];
	wire sda_now  = sda_s[1];
	wire sda_prev = sda_s[2];
	wire scl_rise = scl_now & ~scl_prev;
	wire scl_fall = ~scl_now & scl_prev;
	wire bus_start = scl_now & scl_prev & sda_prev & ~sda_now;
	wire bus_stop  = scl_now & scl_prev & ~sda_prev & sda_now;

	reg  [2:0]           state;
	reg  [3:0]           bit_cnt;
	reg  [7:0]           shreg;
	reg  [7:0]           dev_byte;
	reg  [ADDR_BITS-1:0] ptr;
	reg  [PB_W-1:0]      page_base;
	reg                  pending;
	reg                  first_data;
	reg                  wp_hit;
	reg                  tx_acked;
	reg                  push_valid;
	reg  [11:0]          push_data;
	reg                  commit_req;
	reg                  drop_req;
	reg  [7:0]           mem [0:MEM_BYTES-1];
	reg  [7:0]           pg_data [0:`SEE_PAGE_BYTES-1];
	reg  [`SEE_PAGE_BYTES-1:0] pg_valid;
	reg                  commit_pend;
	reg  [23:0]          busy_cnt;
	wire                 push_ready;
	wire                 pop_valid;
	wire                 pop_ready;
	wire [11:0]          pop_data;

	// Target address decode; strapped address bits skip the compare
	wire [2:0] sel_bits = shreg[`SEE_SEL_HI:`SEE_SEL_LO];
	wire type_ok = (shreg[`SEE_TYPE_HI:`SEE_TYPE_LO] == DEV_TYPE);
	wire sel_ok  = (((sel_bits ^ strap_s) & CMP_MASK) == 3'h0);
	wire busy_any = write_busy_o | commit_pend;
	wire [10:0] full_addr = {dev_byte[`SEE_SEL_HI:`SEE_SEL_LO], shreg};
	wire [7:0]  rd_byte = mem[ptr];

	// Bus protocol engine: bit counting, acknowledge and transmit
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state      <= ST_IDLE;
			bit_cnt    <= `SEE_BIT_NONE;
			shreg      <= 8'h00;
			dev_byte   <= 8'h00;
			ptr        <= {ADDR_BITS{1'b0}};
			page_base  <= {PB_W{1'b0}};
			pending    <= 1'b0;
			first_data <= 1'b0;
			wp_hit     <= 1'b0;
			tx_acked   <= 1'b0;
			push_valid <= 1'b0;
			push_data  <= 12'h000;
			commit_req <= 1'b0;
			drop_req   <= 1'b0;
			sda_o      <= 1'b0;
			sda_oe_b_o <= 1'b1;
		end else begin
			push_valid <= 1'b0;
			commit_req <= 1'b0;
			drop_req   <= 1'b0;
			if (bus_start) begin
				state      <= ST_DEV;
				bit_cnt    <= `SEE_BIT_NONE;
				sda_oe_b_o <= 1'b1;
			end else if (bus_stop) begin
				state      <= ST_IDLE;
				sda_oe_b_o <= 1'b1;
				commit_req <= pending;
				pending    <= 1'b0;
			end else if (state == ST_IDLE) begin
				bit_cnt    <= `SEE_BIT_NONE;
				sda_oe_b_o <= 1'b1;
			end else if (scl_rise) begin
				bit_cnt <= bit_cnt + 1'b1;
				if (state != ST_TX && bit_cnt < `SEE_BITS_LAST)
					shreg <= {shreg[6:0], sda_now};
				if (state == ST_TX && bit_cnt == `SEE_BITS_LAST)
					tx_acked <= ~sda_now;
			end else if (scl_fall) begin
				if (bit_cnt == `SEE_BIT_ACK) begin
					sda_oe_b_o <= 1'b1;
					bit_cnt    <= `SEE_BIT_NONE;
					if (state == ST_DATA && first_data) begin
						wp_hit     <= wp_s[1];
						first_data <= 1'b0;
					end
					if (state == ST_TX) begin
						if (tx_acked) begin
							shreg      <= rd_byte;
							sda_oe_b_o <= rd_byte[7];
							ptr        <= ptr + 1'b1;
						end else begin
							state <= ST_IDLE;
						end
					end
				end else if (bit_cnt == `SEE_BITS_LAST) begin
					case (state)
					ST_DEV: begin
						if (type_ok & sel_ok & ~busy_any) begin
							sda_oe_b_o <= 1'b0;
							dev_byte   <= shreg;
							tx_acked   <= 1'b1;
							if (shreg[`SEE_RW_BIT])
								state <= ST_TX;
							else
								state <= ST_WADDR;
						end else begin
							state <= ST_IDLE;
						end
					end
					ST_WADDR: begin
						sda_oe_b_o <= 1'b0;
						ptr        <= full_addr[ADDR_BITS-1:0];
						page_base  <=
							full_addr[ADDR_BITS-1:`SEE_PAGE_W];
						first_data <= 1'b1;
						wp_hit     <= 1'b0;
						state      <= ST_DATA;
					end
					ST_DATA: begin
						if (wp_hit | ~push_ready) begin
							state    <= ST_IDLE;
							pending  <= 1'b0;
							drop_req <= 1'b1;
						end else begin
							sda_oe_b_o <= 1'b0;
							push_valid <= 1'b1;
							push_data  <= {ptr[`SEE_PAGE_W-1:0], shreg};
							pending    <= 1'b1;
							ptr[`SEE_PAGE_W-1:0] <=
								ptr[`SEE_PAGE_W-1:0] + `SEE_LOW_ADDR_INC;
						end
					end
					ST_TX: begin
						sda_oe_b_o <= 1'b1;
					end
					default: begin
						state <= ST_IDLE;
					end
					endcase
				end else if (state == ST_TX) begin
					shreg      <= {shreg[6:0], 1'b0};
					sda_oe_b_o <= shreg[6];
				end
			end
		end
	end

	// Received bytes queue toward the page buffer; a full queue
	// turns the data byte into a no-ack and drops the buffered page
	see_fifo #(
		.W  (12),
		.AW (1)
	) u_fifo (
		.clk_i       (ref_clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (push_data),
		.out_valid_o (pop_valid),
		.out_ready_i (pop_ready),
		.out_data_o  (pop_data)
	);

	// Drain stalls during the timed write, when the array is locked
	assign pop_ready = ~(write_busy_o & ~commit_pend);

	// Page buffer, array commit and write cycle timer
	integer i;
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (i = 0; i < MEM_BYTES; i = i + 1)
				mem[i] <= `SEE_ERASED;
			for (i = 0; i < `SEE_PAGE_BYTES; i = i + 1)
				pg_data[i] <= `SEE_ERASED;
			pg_valid     <= {`SEE_PAGE_BYTES{1'b0}};
			commit_pend  <= 1'b0;
			busy_cnt     <= 24'h000000;
			write_busy_o <= 1'b0;
		end else begin
			if (pop_valid & pop_ready) begin
				pg_data[pop_data[11:8]]  <= pop_data[7:0];
				pg_valid[pop_data[11:8]] <= 1'b1;
			end
			if (drop_req)
				pg_valid <= {`SEE_PAGE_BYTES{1'b0}};
			if (commit_req) begin
				commit_pend  <= 1'b1;
				write_busy_o <= 1'b1;
			end else if (commit_pend & ~pop_valid) begin
				for (i = 0; i < `SEE_PAGE_BYTES; i = i + 1)
					if (pg_valid[i])
						mem[{page_base, i[3:0]}] <= pg_data[i];
				pg_valid    <= {`SEE_PAGE_BYTES{1'b0}};
				commit_pend <= 1'b0;
				busy_cnt    <= WR_CYCLES;
			end else if (write_busy_o) begin
				if (busy_cnt <= 24'h000001)
					write_busy_o <= 1'b0;
				else
					busy_cnt <= busy_cnt - 1'b1;
			end
		end
	end
endmodule

// ===== see_target_properties.sv
// Checker for the memory target's SDA drive and write busy flag.
// Assumes bus pins are slow against ref_clk_i; bound to see_target.
`timescale 1ns/10ps
module see_target_props #(
	parameter        ADDR_BITS = 11,
	parameter [3:0]  DEV_TYPE  = 4'h5,
	parameter [23:0] WR_CYCLES = 24'h0000c8
) (
	input wire ref_clk_i,
	input wire rst_b_i,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_b_o,
	input wire wp_i,
	input wire strap_select_bit0_i,
	input wire strap_select_bit1_i,
	input wire strap_select_bit2_i,
	input wire write_busy_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [23:0] busy_cnt;
	// Length of the current busy stretch, for the write time check
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			busy_cnt <= 24'h000000;
		else if (write_busy_o)
			busy_cnt <= busy_cnt + 24'h000001;
		else
			busy_cnt <= 24'h000000;
	end
	a_drive_low_only: assert property (!sda_o)
		else $error("sda drive value not low");
	a_reset_standby: assert property ($rose(rst_b_i) |->
		sda_oe_b_o && !write_busy_o) else $error("not idle after reset");
	a_edge_after_fall: assert property ($changed(sda_oe_b_o) |->
		!scl_i && !$past(scl_i, 2)) else $error("sda moved near scl high");
	a_busy_quiet: assert property (write_busy_o |-> sda_oe_b_o)
		else $error("sda pulled while busy");
	a_ack_hold: assert property ($fell(sda_oe_b_o) |->
		!sda_oe_b_o [*8]) else $error("pulled bit too short");
	a_busy_span: assert property ($fell(write_busy_o) |->
		busy_cnt >= WR_CYCLES && busy_cnt <= WR_CYCLES + 24'h000004)
		else $error("write cycle length wrong");
	a_busy_after_stop: assert property ($rose(write_busy_o) |->
		scl_i && sda_i && $past(scl_i, 3)) else $error("busy not at stop");
	a_busy_holds: assert property ($rose(write_busy_o) |->
		write_busy_o [*8]) else $error("busy pulse too short");
	c_write: cover property ($rose(write_busy_o));
	c_ack: cover property ($fell(sda_oe_b_o));
	c_prot: cover property (wp_i && $fell(scl_i));
endmodule
bind see_target see_target_props #(
	.ADDR_BITS(ADDR_BITS),
	.DEV_TYPE (DEV_TYPE),
	.WR_CYCLES(WR_CYCLES)
) see_target_props_i (.*);

// ===== see_ctl.sv
// Bus controller model: makes SCL, START, STOP and nine-bit slots.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/10ps
module see_ctl (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o,
	output logic      done_o,
	output logic [8:0] res_o
);
	// Both lines start released and still before the first frame
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		done_o = 1'b0;
		res_o = 9'h000;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// start, stop: SDA sets up while SCL is low, then changes while SCL is high
	task automatic frame(input logic a, input logic b);
		scl_o <= 1'b0;
		w(3);
		sda_o <= a;
		w(3);
		scl_o <= 1'b1;
		w(6);
		sda_o <= b;
		w(6);
	endtask
	// MSB first, ninth slot acknowledges, one is released
	task automatic xfer(input logic [8:0] tx);
		logic [8:0] rx;
		for (int i = 8; i >= 0; i--) begin
			scl_o <= 1'b0;
			w(3);
			sda_o <= tx[i];
			w(3);
			scl_o <= 1'b1;
			w(3);
			rx[i] = sda_i;
			w(3);
		end
		res_o <= rx;
		done_o <= 1'b1;
		w(1);
		done_o <= 1'b0;
	endtask
endmodule

// ===== tb_see_target.sv
// Bench for see_target: controller model, memory image, byte compare.
// Assumes a 250 MHz core clock and a pulled-up SDA wire.
`timescale 1ns/10ps
module tb_see_target;
	logic       ref_clk_i, rst_b_i, wp, oe_b, sda_d, busy, scl, m_sda, done;
	logic [2:0] strap;
	logic [8:0] res, q[$];
	logic [7:0] mem [256];
	logic [31:0] seed = 32'h000148a6;
	int         failures = 0, n_tests = 0;
	// Open-drain wire: anyone pulling low wins, else pull-up
	wire sda_w = m_sda & (oe_b | sda_d);
	// Type code is arbitrary, shortened write cycle for simulation
	see_target #(.ADDR_BITS(8), .DEV_TYPE(4'h5), .WR_CYCLES(24'h0000c8))
	see_target_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_d), .sda_oe_b_o(oe_b), .wp_i(wp),
		.strap_select_bit0_i(strap[0]), .strap_select_bit1_i(strap[1]),
		.strap_select_bit2_i(strap[2]), .write_busy_o(busy));
	see_ctl see_ctl_i (.clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl),
		.sda_o(m_sda), .done_o(done), .res_o(res));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tally_and_finish();
		if (q.size() != 0) begin
			failures++;
			$display("ERROR notes_left expected 0 seen %0d", q.size());
		end
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] e, input logic [8:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("ERROR byte_ack expected %h seen %h", e, g);
		end
	endtask
	// Each finished slot is matched with the oldest note
	always @(posedge ref_clk_i) begin
		if (done === 1'b1) begin
			if (q.size() > 0)
				chk(q.pop_front(), res);
			else begin
				failures++;
				$display("ERROR byte_ack expected none seen %h", res);
			end
		end
	end
	task automatic tx(input logic [7:0] d, input logic ack);
		q.push_back({d, ack});
		see_ctl_i.xfer({d, 1'b1});
	endtask
	task automatic rx(input logic [7:0] d, input logic last);
		q.push_back({d, last});
		see_ctl_i.xfer({8'hff, last});
	endtask
	task automatic adr(input logic rd, input logic ack);
		see_ctl_i.frame(1'b1, 1'b0);
		tx({4'h5, strap, rd}, ack);
	endtask
	task automatic wait_idle();
		int k = 0;
		while (busy !== 1'b0 && k < 400) begin
			@(posedge ref_clk_i);
			k++;
		end
		if (k >= 400) begin
			failures++;
			tally_and_finish();
		end
	endtask
	// Dummy write sets the pointer, then read n bytes, last one not acked
	task automatic rd(input logic [7:0] a, input int n);
		adr(1'b0, 1'b0);
		tx(a, 1'b0);
		adr(1'b1, 1'b0);
		for (int i = 0; i < n; i++)
			rx(mem[8'(a + i)], i == n - 1);
		see_ctl_i.frame(1'b0, 1'b1);
	endtask
	// Write n random bytes; low four address bits wrap inside the page
	task automatic wr(input logic [7:0] a, input int n, input logic p);
		adr(1'b0, 1'b0);
		tx(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			seed = nx(seed);
			if (!p)
				mem[{a[7:4], 4'(a[3:0] + i)}] = seed[7:0];
			tx(seed[7:0], p);
		end
		see_ctl_i.frame(1'b0, 1'b1);
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		failures++;
		tally_and_finish();
	end
	initial begin
		rst_b_i = 1'b0;
		wp = 1'b0;
		strap = 3'h0;
		foreach (mem[i]) mem[i] = 8'hff;
		seed = nx(seed);
		@(posedge ref_clk_i);
		strap <= seed[2:0];
		repeat (19) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(8'h3e, 1);
		wr(8'h3e, 18, 1'b0);
		adr(1'b0, 1'b1);
		see_ctl_i.frame(1'b0, 1'b1);
		wait_idle();
		wr(8'h00, 1, 1'b0);
		wait_idle();
		rd(8'h30, 16);
		rd(8'hff, 2);
		// Current address read continues where the last read stopped
		rd(8'h3d, 1);
		adr(1'b1, 1'b0);
		rx(mem[8'h3e], 1'b1);
		see_ctl_i.frame(1'b0, 1'b1);
		wp <= 1'b1;
		wr(8'h50, 1, 1'b1);
		wp <= 1'b0;
		rd(8'h50, 1);
		see_ctl_i.frame(1'b1, 1'b0);
		tx({4'h6, strap, 1'b0}, 1'b1);
		tx(8'h00, 1'b1);
		for (int b = 0; b < 3; b++) begin
			see_ctl_i.frame(1'b1, 1'b0);
			tx({4'h5, strap ^ 3'(1 << b), 1'b1}, 1'b1);
		end
		see_ctl_i.frame(1'b0, 1'b1);
		rst_b_i <= 1'b0;
		repeat (20) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		foreach (mem[i]) mem[i] = 8'hff;
		repeat (4) @(posedge ref_clk_i);
		rd(8'h00, 1);
		repeat (20) @(posedge ref_clk_i);
		tally_and_finish();
	end
endmodule
